// >>> bench/gdc_host_model.sv
`timescale 1ns/1ps
module gdc_host_model (
	// serial link to the reader
	output logic spi_sclk,
	output logic chip_select_n,
	output logic spi_mosi
);
	initial
	begin
		spi_sclk = 1'b0;
		chip_select_n = 1'b0;
		spi_mosi = 1'b0;
		// a clean rising edge clears the link counters
		#1 chip_select_n = 1'b1;
	end
	// =====================================================
	// byte out, msb first, clock still outside bytes
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
		begin
			// data moves after the falling edge, never on it
			#2 spi_mosi = b[i];
			#5.5 spi_sclk = 1'b1;
			#7.5 spi_sclk = 1'b0;
		end
	endtask
	// =====================================================
	// gap between bytes so the slow core sees each one
	task automatic frame(input logic [7:0] cmd, input int n, input logic [7:0] nxt);
		chip_select_n = 1'b0;
		#10 send_byte(cmd);
		for (int k = 0; k < n; k++)
		begin
			#300 send_byte(nxt + 8'(k));
		end
		#75 chip_select_n = 1'b1;
		spi_mosi = ~spi_mosi;
	endtask
endmodule

// >>> bench/gdc_properties.sv
`timescale 1ns/1ps
module gdc_checker
	import gdc_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// inputs watched
	input wire logic rx_rn_valid,
	input wire logic tx_bit_ready,
	// outputs watched
	input wire logic tx_frame_start,
	input wire logic tx_preamble,
	input wire logic tx_bit_valid,
	input wire logic tx_bit,
	input wire logic fifo_wr,
	input wire logic [7:0] fifo_wdata,
	input wire logic [15:0] rn16_hold,
	input wire logic agl_on,
	input wire logic acol_en,
	input wire logic cmd_busy,
	input wire logic irq_cmd_set,
	input wire logic chain_byte_stb,
	input wire logic [7:0] chain_byte,
	input wire logic clsys_out,
	input wire gdc_drive_cfg_t drive_cfg
);
	// =====================================================
	// assertions
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	irq_pulse_a: assert property (irq_cmd_set |-> cmd_busy ##1 !irq_cmd_set)
		else $error("done request not a single busy cycle");
	agl_done_a: assert property ($changed(agl_on) |=> irq_cmd_set)
		else $error("gain limiting change without done");
	acol_done_a: assert property ($changed(acol_en) |=> irq_cmd_set)
		else $error("anti-collision change without done");
	rn_copy_a: assert property ($changed(rn16_hold) |=> fifo_wr && fifo_wdata == rn16_hold[15:8]
		##1 fifo_wr && fifo_wdata == rn16_hold[7:0] ##1 irq_cmd_set)
		else $error("held handle not copied high then low");
	fifo_cause_a: assert property ($rose(fifo_wr) |-> $past(rx_rn_valid, 2))
		else $error("copy written without a reply");
	tx_hold_a: assert property (tx_bit_valid && !tx_bit_ready |=> tx_bit_valid && $stable(tx_bit))
		else $error("bit dropped or changed while stalled");
	frame_valid_a: assert property (tx_frame_start |-> tx_bit_valid)
		else $error("frame start without a bit");
	query_first_a: assert property (tx_frame_start && tx_preamble |-> tx_bit)
		else $error("query frame does not open with one");
	clk_od_a: assert property (drive_cfg.pull_down_only_drive && $past(drive_cfg.pull_down_only_drive)
		|-> !clsys_out)
		else $error("clock pin driven high in pull-down mode");
	chain_pulse_a: assert property (chain_byte_stb |=> !chain_byte_stb && $stable(chain_byte))
		else $error("chained byte strobe too long");
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench
	import gdc_pkg::*;
;
	logic core_clk = 1'b0;
	logic sys_rst;
	logic core_ce = 1'b1;
	logic spi_sclk, chip_select_n, spi_mosi;
	gdc_query_param_t fifo_query_param = '0;
	logic [1:0] tx_session = 2'h2;
	gdc_drive_cfg_t misc_drive = 2'b10;
	gdc_drive_cfg_t drive_cfg;
	logic [2:0] clsys_sel = 3'h0;
	logic supply_adj_done = 1'b0;
	logic vco_sel_done = 1'b0;
	logic tx_bit_ready = 1'b0;
	logic rx_rn_valid = 1'b0;
	logic rx_no_reply = 1'b0;
	logic [15:0] rx_rn16 = 16'h0000;
	logic [15:0] rn16_hold, hold_exp;
	logic [7:0] fifo_wdata, chain_byte;
	logic tx_frame_start, tx_preamble, tx_bit_valid, tx_bit, fifo_wr, supply_auto;
	logic supply_adj_start, vco_auto, vco_sel_start, agl_on, rssi_store, rssi_clear;
	logic acol_en, cmd_busy, irq_cmd_set, chain_byte_stb, clsys_out, clsys_oe_n, clsys_pass;
	logic txq[$];
	logic pre_seen;
	logic [7:0] fifo_b[$];
	int n_mismatch = 0;
	int n_tests = 0;
	int cyc = 0;
	int n_irq, n_chain, n_pulse;
	integer seed = 32'h4060;

	gdc_direct_cmd_exec DUT (.*);
	gdc_host_model HOST (.spi_sclk(spi_sclk), .chip_select_n(chip_select_n), .spi_mosi(spi_mosi));

	always #25 core_clk = ~core_clk;

	// =====================================================
	// modulator, helpers and monitors
	always @(posedge core_clk)
	begin
		tx_bit_ready <= ($random(seed) & 3) != 0;
		supply_adj_done <= supply_adj_start;
		vco_sel_done <= vco_sel_start;
		if (tx_bit_valid && tx_bit_ready)
			txq.push_back(tx_bit);
		if (fifo_wr)
			fifo_b.push_back(fifo_wdata);
		if (tx_frame_start)
			pre_seen = tx_preamble;
		n_irq += irq_cmd_set;
		n_chain += chain_byte_stb;
		n_pulse += rssi_store + rssi_clear + supply_adj_start + vco_sel_start;
		cyc++;
		if (cyc == 30000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic check(input logic ok, input string what);
		n_tests++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask

	function automatic bit same_q(input logic a[$], input logic b[$]);
		if (a.size() != b.size())
			return 1'b0;
		foreach (a[i])
			if (a[i] !== b[i])
				return 1'b0;
		return 1'b1;
	endfunction

	function automatic void put(ref logic q[$], input logic [39:0] v, input int n);
		for (int i = n - 1; i >= 0; i--)
			q.push_back(v[i]);
	endfunction

	// crc5 kept in low bits; crc16 goes out inverted
	function automatic logic [15:0] crc(input logic q[$], input int w);
		logic [15:0] r;
		r = (w == 5) ? 16'h0009 : 16'hFFFF;
		foreach (q[i])
			r = {r[14:0], 1'b0} ^ ((((w == 5) ? r[4] : r[15]) ^ q[i]) ? ((w == 5) ? 16'h0009 : 16'h1021) : 16'h0000);
		return (w == 5) ? (r & 16'h001F) : ~r;
	endfunction

	function automatic void expect_q(input logic [7:0] c, ref logic q[$]);
		q = {};
		case (c)
			CMD_QUERY: put(q, {4'h8, fifo_query_param[13:1]}, 17);
			CMD_QREP: put(q, {2'h0, tx_session}, 4);
			CMD_QADJ_UP: put(q, {4'h9, tx_session, 3'h6}, 9);
			CMD_QADJ_NC: put(q, {4'h9, tx_session, 3'h0}, 9);
			CMD_QADJ_DN: put(q, {4'h9, tx_session, 3'h3}, 9);
			CMD_ACK: put(q, {2'h1, hold_exp}, 18);
			CMD_NAK: put(q, 8'hC0, 8);
			CMD_REQRN: put(q, {8'hC1, hold_exp}, 24);
			default: q = {};
		endcase
		if (c == CMD_QUERY)
			put(q, crc(q, 5), 5);
		if (c == CMD_REQRN)
			put(q, crc(q, 16), 16);
	endfunction

	// rep: 0 no reply wanted, 1 tag answers, 2 tag silent
	task automatic run(input logic [7:0] c, input int n, input int rep, input int ni);
		logic q[$];
		txq = {};
		fifo_b = {};
		n_irq = 0;
		n_chain = 0;
		n_pulse = 0;
		pre_seen = 1'b0;
		expect_q(c, q);
		HOST.frame(c, n, 8'h3C);
		for (int k = 0; k < 400 && txq.size() < q.size(); k++)
			@(negedge core_clk);
		if (rep != 0)
		begin
			repeat (3) @(posedge core_clk);
			if (rep == 1)
				hold_exp = 16'($random(seed));
			rx_rn16 <= hold_exp;
			rx_rn_valid <= (rep == 1);
			rx_no_reply <= (rep == 2);
			@(posedge core_clk);
			rx_rn_valid <= 1'b0;
			rx_no_reply <= 1'b0;
		end
		for (int k = 0; k < 60 && n_irq == 0; k++)
			@(negedge core_clk);
		repeat (4) @(negedge core_clk);
		check(same_q(txq, q), "transmitted bits");
		if (q.size() != 0)
			check(pre_seen === (c == CMD_QUERY), "preamble choice");
		check(n_irq == ni, "done request count");
		check(n_chain == n && (n == 0 || chain_byte === 8'h3C + 8'(n - 1)), "chained bytes");
		check(rn16_hold === hold_exp, "held handle");
		check(fifo_b.size() == ((rep == 1) ? 2 : 0), "copy count");
		if (rep == 1)
			check(fifo_b[0] === hold_exp[15:8] && fifo_b[1] === hold_exp[7:0], "copy bytes");
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		logic [7:0] c;
		logic [4:0] e;
		int ro, re, hi, d;
		// scheduled change gives the link side a real reset edge
		sys_rst <= 1'b1;
		hold_exp = 16'h0000;
		e = 5'h00;
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		fifo_query_param <= {2'b00, 14'($random(seed))};
		@(negedge core_clk);
		check(drive_cfg === 2'b10 && rn16_hold === 16'h0000, "reset state");
		// =====================================================
		// inventory sequence
		run(CMD_QUERY, 0, 1, 1);
		run(CMD_ACK, 0, 0, 1);
		run(CMD_QREP, 0, 2, 1);
		run(CMD_QADJ_UP, 0, 1, 1);
		run(CMD_QADJ_NC, 0, 1, 1);
		run(CMD_QADJ_DN, 0, 1, 1);
		run(CMD_NAK, 0, 0, 1);
		run(CMD_REQRN, 0, 1, 1);
		run(CMD_ACK, 0, 0, 1);
		// =====================================================
		// function commands, each once then random ones
		for (int k = 0; k < 16; k++)
		begin
			c = (k < 10) ? 8'hA2 + 8'(k) : 8'hA2 + 8'(($random(seed) & 32'hFF) % 10);
			if (c[3:1] != 3'h4)
				e[(c - 8'hA2) >> 1] = ~c[0];
			run(c, (k == 4) ? 2 : 0, 0, 1);
			check({acol_en, 1'b0, agl_on, vco_auto, supply_auto} === e, "function levels");
			check(n_pulse == (c == 8'hA2 || c == 8'hA4 || c == 8'hA8 || c == 8'hA9), "start pulses");
		end
		// =====================================================
		// undefined ids and a non-command byte change nothing
		for (int i = 0; i < 5; i++)
		begin
			c = (i == 0) ? 8'hA0 : (i == 1) ? 8'hA1 : (i == 2) ? 8'hAC : (i == 3) ? 8'hBF : 8'h26;
			run(c, 0, 0, 0);
			check({acol_en, 1'b0, agl_on, vco_auto, supply_auto} === e, "state after ignored id");
		end
		// =====================================================
		// clock output rates, then drive options
		for (int s = 0; s < 5; s++)
		begin
			@(posedge core_clk);
			clsys_sel <= (s == 4) ? 3'h0 : 3'(s);
			misc_drive <= (s == 4) ? 2'b01 : 2'b10;
			repeat (12) @(negedge core_clk);
			ro = 0;
			re = 0;
			hi = 0;
			for (int k = 0; k < 40; k++)
			begin
				d = clsys_out;
				hi = clsys_oe_n;
				@(negedge core_clk);
				ro += (clsys_out === 1'b1 && d == 0);
				re += (clsys_oe_n === 1'b1 && hi == 0);
			end
			d = (s == 0 || s == 4) ? 5 : (s == 1) ? 4 : 2;
			check(clsys_pass === (s == 3), "bypass select");
			if (s < 3)
				check(ro == 40 / d, "clock output rate");
			if (s == 4)
				check(ro == 0 && re == 8 && drive_cfg === 2'b01, "pull-down drive");
		end
		tally_and_finish();
	end
endmodule

bind gdc_direct_cmd_exec gdc_checker CHK (.*);

// >>> design/gdc_direct_cmd_exec.sv
`timescale 1ns/1ps
module gdc_direct_cmd_exec
	import gdc_pkg::*;
(
	// core clock and control
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic core_ce,
	// host serial link
	input wire logic spi_sclk,
	input wire logic chip_select_n,
	input wire logic spi_mosi,
	// settings from the register file
	input wire gdc_query_param_t fifo_query_param,
	input wire logic [1:0] tx_session,
	input wire gdc_drive_cfg_t misc_drive,
	input wire logic [2:0] clsys_sel,
	// analog helpers
	input wire logic supply_adj_done,
	input wire logic vco_sel_done,
	// modulator and receiver
	input wire logic tx_bit_ready,
	input wire logic rx_rn_valid,
	input wire logic [15:0] rx_rn16,
	input wire logic rx_no_reply,
	// transmit bit stream
	output logic tx_frame_start,
	output logic tx_preamble,
	output logic tx_bit_valid,
	output logic tx_bit,
	// fifo copy of rn16
	output logic fifo_wr,
	output logic [7:0] fifo_wdata,
	output logic [15:0] rn16_hold,
	// functions
	output logic supply_auto,
	output logic supply_adj_start,
	output logic vco_auto,
	output logic vco_sel_start,
	output logic agl_on,
	output logic rssi_store,
	output logic rssi_clear,
	output logic acol_en,
	// status
	output logic cmd_busy,
	output logic irq_cmd_set,
	// chained register access bytes
	output logic chain_byte_stb,
	output logic [7:0] chain_byte,
	// clock output pin and drive
	output logic clsys_out,
	output logic clsys_oe_n,
	output logic clsys_pass,
	output gdc_drive_cfg_t drive_cfg
);

	// =====================================================
	// link side, host serial clock
	logic [2:0] lk_bitcnt_reg;
	logic [6:0] lk_shift_reg;
	logic lk_first_reg;
	logic lk_dc_frame_reg;
	logic [7:0] lk_cmd_reg;
	logic [7:0] lk_chain_reg;
	logic lk_cmd_tgl_reg;
	logic lk_chain_tgl_reg;
	logic lk_byte_end;
	logic lk_is_dc;

	assign lk_byte_end = (lk_bitcnt_reg == 3'h7);
	assign lk_is_dc = (lk_shift_reg[6:5] == DC_MODE);

	// frame counters restart whenever chip select is high
	always_ff @(negedge spi_sclk or posedge chip_select_n)
	begin
		if (chip_select_n)
		begin
			lk_bitcnt_reg <= 3'h0;
			lk_first_reg <= 1'b1;
			lk_dc_frame_reg <= 1'b0;
		end
		else
		begin
			lk_bitcnt_reg <= lk_bitcnt_reg + 3'h1;
			if (lk_byte_end)
			begin
				lk_first_reg <= 1'b0;
				if (lk_first_reg)
					lk_dc_frame_reg <= lk_is_dc;
			end
		end
	end

	always_ff @(negedge spi_sclk)
	begin
		lk_shift_reg <= {lk_shift_reg[5:0], spi_mosi};
	end

	// held bytes stay stable for a whole byte time, far longer than the crossing
	always_ff @(negedge spi_sclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			lk_cmd_reg <= 8'h00;
			lk_chain_reg <= 8'h00;
			lk_cmd_tgl_reg <= 1'b0;
			lk_chain_tgl_reg <= 1'b0;
		end
		else if (!chip_select_n && lk_byte_end)
		begin
			if (lk_first_reg && lk_is_dc)
			begin
				lk_cmd_reg <= {lk_shift_reg, spi_mosi};
				lk_cmd_tgl_reg <= ~lk_cmd_tgl_reg;
			end
			else if (!lk_first_reg && lk_dc_frame_reg)
			begin
				lk_chain_reg <= {lk_shift_reg, spi_mosi};
				lk_chain_tgl_reg <= ~lk_chain_tgl_reg;
			end
		end
	end

	// =====================================================
	// crossing into the core domain
	logic [2:0] cmd_sync_reg;
	logic [2:0] chain_sync_reg;
	logic cmd_evt;
	logic chain_evt;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			cmd_sync_reg <= 3'h0;
			chain_sync_reg <= 3'h0;
		end
		else if (core_ce)
		begin
			cmd_sync_reg <= {cmd_sync_reg[1:0], lk_cmd_tgl_reg};
			chain_sync_reg <= {chain_sync_reg[1:0], lk_chain_tgl_reg};
		end
	end

	assign cmd_evt = cmd_sync_reg[2] ^ cmd_sync_reg[1];
	assign chain_evt = chain_sync_reg[2] ^ chain_sync_reg[1];

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			chain_byte_stb <= 1'b0;
			chain_byte <= 8'h00;
		end
		else if (core_ce)
		begin
			chain_byte_stb <= chain_evt;
			if (chain_evt)
				chain_byte <= lk_chain_reg;
		end
	end

	// =====================================================
	// command decode
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_SEND = 8'h02,
		ST_WAIT_RN = 8'h04,
		ST_PUSH_HI = 8'h08,
		ST_PUSH_LO = 8'h10,
		ST_WAIT_ANA = 8'h20,
		ST_DONE = 8'h40
	} gdc_state_t;

	gdc_state_t state_reg;
	logic [39:0] ld_frame;
	logic [5:0] ld_len;
	gdc_crc_kind_t ld_crc;
	logic ld_tx;
	logic ld_pre;
	logic ld_expect;
	logic expect_reg;

	always_comb
	begin
		ld_frame = 40'h0;
		ld_len = 6'h0;
		ld_crc = GDC_CRC_NONE;
		ld_tx = 1'b1;
		ld_pre = 1'b0;
		ld_expect = 1'b1;
		unique case (lk_cmd_reg)
			CMD_QUERY:
			begin
				ld_frame = {G2_QUERY, fifo_query_param[13:1], 23'h0};
				ld_len = 6'd17;
				ld_crc = GDC_CRC_5;
				ld_pre = 1'b1;
			end
			CMD_QREP:
			begin
				ld_frame = {G2_QREP, tx_session, 36'h0};
				ld_len = 6'd4;
			end
			CMD_QADJ_UP:
			begin
				ld_frame = {G2_QADJ, tx_session, G2_UPDN_UP, 31'h0};
				ld_len = 6'd9;
			end
			CMD_QADJ_NC:
			begin
				ld_frame = {G2_QADJ, tx_session, G2_UPDN_NC, 31'h0};
				ld_len = 6'd9;
			end
			CMD_QADJ_DN:
			begin
				ld_frame = {G2_QADJ, tx_session, G2_UPDN_DN, 31'h0};
				ld_len = 6'd9;
			end
			CMD_ACK:
			begin
				ld_frame = {G2_ACK, rn16_hold, 22'h0};
				ld_len = 6'd18;
				ld_expect = 1'b0;
			end
			CMD_NAK:
			begin
				ld_frame = {G2_NAK, 32'h0};
				ld_len = 6'd8;
				ld_expect = 1'b0;
			end
			CMD_REQRN:
			begin
				ld_frame = {G2_REQRN, rn16_hold, 16'h0};
				ld_len = 6'd24;
				ld_crc = GDC_CRC_16;
			end
			default:
			begin
				ld_tx = 1'b0;
				ld_expect = 1'b0;
			end
		endcase
	end

	// =====================================================
	// sequencing
	logic tx_last;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			state_reg <= ST_IDLE;
			expect_reg <= 1'b0;
		end
		else if (core_ce)
		begin
			unique case (state_reg)
				ST_IDLE:
				begin
					// busy periods drop commands, the host must wait for the interrupt
					if (cmd_evt)
					begin
						expect_reg <= ld_expect;
						if (ld_tx)
							state_reg <= ST_SEND;
						else if (lk_cmd_reg == CMD_SUPPLY_AUTO || lk_cmd_reg == CMD_VCO_AUTO)
							state_reg <= ST_WAIT_ANA;
						else if (lk_cmd_reg[7:4] == 4'hA && lk_cmd_reg[3:0] >= 4'h3
							&& lk_cmd_reg[3:0] <= 4'hB)
							state_reg <= ST_DONE;
					end
				end
				ST_SEND:
					if (tx_last)
						state_reg <= expect_reg ? ST_WAIT_RN : ST_DONE;
				ST_WAIT_RN:
					if (rx_rn_valid)
						state_reg <= ST_PUSH_HI;
					else if (rx_no_reply)
						state_reg <= ST_DONE;
				ST_PUSH_HI:
					state_reg <= ST_PUSH_LO;
				ST_PUSH_LO:
					state_reg <= ST_DONE;
				ST_WAIT_ANA:
					if (supply_adj_done || vco_sel_done)
						state_reg <= ST_DONE;
				ST_DONE:
					state_reg <= ST_IDLE;
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// =====================================================
	// bit serialiser with crc
	function automatic logic [4:0] crc5_upd(input logic [4:0] c, input logic b);
		crc5_upd = (c[4] ^ b) ? ({c[3:0], 1'b0} ^ CRC5_POLY) : {c[3:0], 1'b0};
	endfunction

	function automatic logic [15:0] crc16_upd(input logic [15:0] c, input logic b);
		crc16_upd = (c[15] ^ b) ? ({c[14:0], 1'b0} ^ CRC16_POLY) : {c[14:0], 1'b0};
	endfunction

	logic [39:0] frame_reg;
	logic [5:0] left_reg;
	logic in_crc_reg;
	gdc_crc_kind_t crc_kind_reg;
	logic [4:0] crc5_reg;
	logic [15:0] crc16_reg;
	logic [15:0] crc_out_reg;
	logic [4:0] crc5_next;
	logic [15:0] crc16_next;
	logic xfer;

	assign xfer = tx_bit_valid && tx_bit_ready;
	assign tx_last = xfer && (left_reg == 6'h1) && (in_crc_reg || crc_kind_reg == GDC_CRC_NONE);
	assign crc5_next = crc5_upd(crc5_reg, tx_bit);
	assign crc16_next = crc16_upd(crc16_reg, tx_bit);

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			frame_reg <= 40'h0;
			left_reg <= 6'h0;
			in_crc_reg <= 1'b0;
			crc_kind_reg <= GDC_CRC_NONE;
			crc5_reg <= CRC5_INIT;
			crc16_reg <= CRC16_INIT;
			crc_out_reg <= 16'h0;
			tx_bit <= 1'b0;
			tx_bit_valid <= 1'b0;
			tx_frame_start <= 1'b0;
			tx_preamble <= 1'b0;
		end
		else if (core_ce)
		begin
			tx_frame_start <= 1'b0;
			if (state_reg == ST_IDLE && cmd_evt && ld_tx)
			begin
				tx_bit <= ld_frame[39];
				frame_reg <= {ld_frame[38:0], 1'b0};
				left_reg <= ld_len;
				in_crc_reg <= 1'b0;
				crc_kind_reg <= ld_crc;
				crc5_reg <= CRC5_INIT;
				crc16_reg <= CRC16_INIT;
				tx_bit_valid <= 1'b1;
				tx_frame_start <= 1'b1;
				tx_preamble <= ld_pre;
			end
			else if (tx_last)
				tx_bit_valid <= 1'b0;
			else if (xfer && !in_crc_reg)
			begin
				crc5_reg <= crc5_next;
				crc16_reg <= crc16_next;
				if (left_reg == 6'h1)
				begin
					in_crc_reg <= 1'b1;
					if (crc_kind_reg == GDC_CRC_5)
					begin
						left_reg <= 6'd5;
						tx_bit <= crc5_next[4];
						crc_out_reg <= {crc5_next[3:0], 12'h0};
					end
					else
					begin
						left_reg <= 6'd16;
						tx_bit <= ~crc16_next[15];
						crc_out_reg <= {~crc16_next[14:0], 1'b0};
					end
				end
				else
				begin
					left_reg <= left_reg - 6'h1;
					tx_bit <= frame_reg[39];
					frame_reg <= {frame_reg[38:0], 1'b0};
				end
			end
			else if (xfer)
			begin
				left_reg <= left_reg - 6'h1;
				tx_bit <= crc_out_reg[15];
				crc_out_reg <= {crc_out_reg[14:0], 1'b0};
			end
		end
	end

	// =====================================================
	// rn16 holding and fifo copy
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			rn16_hold <= 16'h0;
			fifo_wr <= 1'b0;
			fifo_wdata <= 8'h00;
		end
		else if (core_ce)
		begin
			fifo_wr <= 1'b0;
			if (state_reg == ST_WAIT_RN && rx_rn_valid)
				rn16_hold <= rx_rn16;
			if (state_reg == ST_PUSH_HI)
			begin
				fifo_wr <= 1'b1;
				fifo_wdata <= rn16_hold[15:8];
			end
			if (state_reg == ST_PUSH_LO)
			begin
				fifo_wr <= 1'b1;
				fifo_wdata <= rn16_hold[7:0];
			end
		end
	end

	// =====================================================
	// function switches and completion
	logic func_evt;

	assign func_evt = (state_reg == ST_IDLE) && cmd_evt;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			supply_auto <= 1'b0;
			supply_adj_start <= 1'b0;
			vco_auto <= 1'b0;
			vco_sel_start <= 1'b0;
			agl_on <= 1'b0;
			rssi_store <= 1'b0;
			rssi_clear <= 1'b0;
			acol_en <= 1'b0;
			irq_cmd_set <= 1'b0;
			cmd_busy <= 1'b0;
		end
		else if (core_ce)
		begin
			supply_adj_start <= func_evt && lk_cmd_reg == CMD_SUPPLY_AUTO;
			vco_sel_start <= func_evt && lk_cmd_reg == CMD_VCO_AUTO;
			rssi_store <= func_evt && lk_cmd_reg == CMD_RSSI_STORE;
			rssi_clear <= func_evt && lk_cmd_reg == CMD_RSSI_CLEAR;
			irq_cmd_set <= (state_reg == ST_DONE);
			cmd_busy <= (state_reg != ST_IDLE);
			if (func_evt)
			begin
				unique case (lk_cmd_reg)
					CMD_SUPPLY_AUTO: supply_auto <= 1'b1;
					CMD_SUPPLY_MAN: supply_auto <= 1'b0;
					CMD_VCO_AUTO: vco_auto <= 1'b1;
					CMD_VCO_MAN: vco_auto <= 1'b0;
					CMD_AGL_ON: agl_on <= 1'b1;
					CMD_AGL_OFF: agl_on <= 1'b0;
					CMD_ACOL_EN: acol_en <= 1'b1;
					CMD_ACOL_DIS: acol_en <= 1'b0;
					default: ;
				endcase
			end
		end
	end

	// =====================================================
	// host clock output and drive options
	logic [2:0] div_cnt_reg;
	logic [2:0] div_sel;
	logic clk_level;

	always_comb
	begin
		unique case (clsys_sel)
			CLSYS_SEL_5M: div_sel = CLSYS_DIV_5M;
			CLSYS_SEL_10M: div_sel = CLSYS_DIV_10M;
			default: div_sel = CLSYS_DIV_4M;
		endcase
		// odd divide gives 40 % duty, acceptable for a host clock
		clk_level = (div_cnt_reg < (div_sel >> 1));
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			div_cnt_reg <= 3'h0;
			clsys_out <= 1'b0;
			clsys_oe_n <= 1'b0;
			clsys_pass <= 1'b0;
			drive_cfg <= '{fast_edge_drive: DRV_FAST_RST, pull_down_only_drive: DRV_OD_RST};
		end
		else if (core_ce)
		begin
			div_cnt_reg <= (div_cnt_reg >= div_sel - 3'h1) ? 3'h0 : div_cnt_reg + 3'h1;
			// a register cannot toggle at the core rate, so 20 MHz is a pad bypass
			clsys_pass <= (clsys_sel == CLSYS_SEL_20M);
			drive_cfg <= misc_drive;
			if (misc_drive.pull_down_only_drive)
			begin
				clsys_out <= 1'b0;
				clsys_oe_n <= clk_level;
			end
			else
			begin
				clsys_out <= clk_level;
				clsys_oe_n <= 1'b0;
			end
		end
	end

endmodule

// >>> design/gdc_pkg.sv
// Behaviour
// - 98h sends Query using two FIFO parameter bytes
// - parameter bytes: 00,DR,M,TRext,Sel,Session,Target,Q; LSB ignored
// - Query frame: preamble, command, parameters, CRC-5
// - Query reply RN16 kept and copied to FIFO
// - 99h sends QueryRep with session bits; keep RN16
// - 9Ah sends QueryAdjust up; keep RN16
// - 9Bh sends QueryAdjust no change; keep RN16
// - 9Ch sends QueryAdjust down; keep RN16
// - 9Dh sends ACK with held RN16
// - 9Eh sends NAK
// - 9Fh sends ReqRN with held RN; new handle kept
// - A2h automatic supply levels, A3h manual
// - A4h automatic oscillator range, A5h manual
// - A6h gain limiting on, A7h off
// - A8h stores signal strength, A9h clears it
// - AAh enables anti-collision support, ABh disables
// - accept register accesses chained after direct command
// - host clock output 4, 5, 10, 20 MHz
// - outputs default fast; clear bit gives weak drive
// - open-drain bit makes outputs pull-down only
// - direct command: mode bits 1,0 then six-bit id
// - execution starts at last falling clock edge
// - finished command raises command-done interrupt request
package gdc_pkg;

	// =====================================================
	// direct command codes
	localparam logic [1:0] DC_MODE = 2'h2;
	localparam logic [7:0] CMD_QUERY = 8'h98;
	localparam logic [7:0] CMD_QREP = 8'h99;
	localparam logic [7:0] CMD_QADJ_UP = 8'h9A;
	localparam logic [7:0] CMD_QADJ_NC = 8'h9B;
	localparam logic [7:0] CMD_QADJ_DN = 8'h9C;
	localparam logic [7:0] CMD_ACK = 8'h9D;
	localparam logic [7:0] CMD_NAK = 8'h9E;
	localparam logic [7:0] CMD_REQRN = 8'h9F;
	localparam logic [7:0] CMD_SUPPLY_AUTO = 8'hA2;
	localparam logic [7:0] CMD_SUPPLY_MAN = 8'hA3;
	localparam logic [7:0] CMD_VCO_AUTO = 8'hA4;
	localparam logic [7:0] CMD_VCO_MAN = 8'hA5;
	localparam logic [7:0] CMD_AGL_ON = 8'hA6;
	localparam logic [7:0] CMD_AGL_OFF = 8'hA7;
	localparam logic [7:0] CMD_RSSI_STORE = 8'hA8;
	localparam logic [7:0] CMD_RSSI_CLEAR = 8'hA9;
	localparam logic [7:0] CMD_ACOL_EN = 8'hAA;
	localparam logic [7:0] CMD_ACOL_DIS = 8'hAB;

	// =====================================================
	// register addresses of the surrounding map
	localparam logic [5:0] MISC1_ADDR = 6'h0D;
	localparam logic [5:0] MISC2_ADDR = 6'h0E;
	localparam logic [5:0] IRQ_STAT_ADDR = 6'h38;
	localparam logic [5:0] TX_SET_ADDR = 6'h3C;
	localparam logic [5:0] FIFO_ADDR = 6'h3F;

	// =====================================================
	// air-interface codes
	localparam logic [3:0] G2_QUERY = 4'h8;
	localparam logic [1:0] G2_QREP = 2'h0;
	localparam logic [3:0] G2_QADJ = 4'h9;
	localparam logic [2:0] G2_UPDN_UP = 3'h6;
	localparam logic [2:0] G2_UPDN_NC = 3'h0;
	localparam logic [2:0] G2_UPDN_DN = 3'h3;
	localparam logic [1:0] G2_ACK = 2'h1;
	localparam logic [7:0] G2_NAK = 8'hC0;
	localparam logic [7:0] G2_REQRN = 8'hC1;
	localparam logic [4:0] CRC5_POLY = 5'h09;
	localparam logic [4:0] CRC5_INIT = 5'h09;
	localparam logic [15:0] CRC16_POLY = 16'h1021;
	localparam logic [15:0] CRC16_INIT = 16'hFFFF;

	// =====================================================
	// clock output and drive
	localparam int CORE_CLK_HZ = 20_000_000;
	localparam logic [2:0] CLSYS_SEL_4M = 3'h0;
	localparam logic [2:0] CLSYS_SEL_5M = 3'h1;
	localparam logic [2:0] CLSYS_SEL_10M = 3'h2;
	localparam logic [2:0] CLSYS_SEL_20M = 3'h3;
	localparam logic [2:0] CLSYS_DIV_4M = 3'(CORE_CLK_HZ / 4_000_000);
	localparam logic [2:0] CLSYS_DIV_5M = 3'(CORE_CLK_HZ / 5_000_000);
	localparam logic [2:0] CLSYS_DIV_10M = 3'(CORE_CLK_HZ / 10_000_000);
	localparam logic DRV_FAST_RST = 1'b1;
	localparam logic DRV_OD_RST = 1'b0;

	// =====================================================
	// grouped signals
	typedef struct packed {
		logic [1:0] zero;
		logic dr;
		logic [1:0] m;
		logic trext;
		logic [1:0] sel;
		logic [1:0] session;
		logic target;
		logic [3:0] q;
		logic spare;
	} gdc_query_param_t;

	typedef struct packed {
		logic fast_edge_drive;
		logic pull_down_only_drive;
	} gdc_drive_cfg_t;

	typedef enum logic [1:0] {
		GDC_CRC_NONE = 2'h0,
		GDC_CRC_5 = 2'h1,
		GDC_CRC_16 = 2'h2
	} gdc_crc_kind_t;

endpackage
